//--- hw/tpw_pkg.sv
package tpw_pkg;
  localparam int NUM_MATCH = 7;
  localparam int NUM_CAP = 2;
  localparam int NUM_EXT = 4;
  localparam int NUM_PWM = 6;
  localparam int NUM_DMA = 2;

  // Byte offsets of the register words
  localparam logic [7:0] OFS_STAT = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_TC = 8'h08;
  localparam logic [7:0] OFS_PR = 8'h0C;
  localparam logic [7:0] OFS_PC = 8'h10;
  localparam logic [7:0] OFS_MCR = 8'h14;
  localparam logic [7:0] OFS_CCR = 8'h18;
  localparam logic [7:0] OFS_CAP0 = 8'h1C;
  localparam logic [7:0] OFS_CAP1 = 8'h20;
  localparam logic [7:0] OFS_CNT = 8'h24;
  localparam logic [7:0] OFS_EMR = 8'h28;
  localparam logic [7:0] OFS_PCR = 8'h2C;
  localparam logic [7:0] OFS_LER = 8'h30;
  localparam logic [7:0] OFS_MASK = 8'h34;
  localparam logic [7:0] OFS_MR0 = 8'h40;

  // Control word bits
  localparam int CTRL_EN = 0;
  localparam int CTRL_RST = 1;
  localparam int CTRL_PWM = 2;
  localparam int CTRL_DMA0 = 3;

  // Match control: three bits per match channel
  localparam int MCR_W = 3;
  localparam int MCR_INT = 0;
  localparam int MCR_RST = 1;
  localparam int MCR_STOP = 2;

  // Capture control: three bits per capture channel
  localparam int CCR_W = 3;
  localparam int CCR_RISE = 0;
  localparam int CCR_FALL = 1;
  localparam int CCR_INT = 2;

  // Count source: bits 1:0 mode, bit 2 selects the capture input
  localparam logic [1:0] CNT_TIMER = 2'h0;
  localparam logic [1:0] CNT_RISE = 2'h1;
  localparam logic [1:0] CNT_FALL = 2'h2;
  localparam logic [1:0] CNT_BOTH = 2'h3;
  localparam int CNT_SEL = 2;

  // External match: bits 3:0 pin state, two action bits per pin from bit 4
  localparam int EMR_CTL_LSB = 4;
  localparam logic [1:0] EXT_NONE = 2'h0;
  localparam logic [1:0] EXT_LOW = 2'h1;
  localparam logic [1:0] EXT_HIGH = 2'h2;
  localparam logic [1:0] EXT_TOG = 2'h3;

  // PWM control: bit n selects double edge for channel n (2..6)
  localparam int PCR_OE_LSB = 9;

  // Status and mask: match bits from 0, capture bits from 7
  localparam int STAT_CAP_LSB = 7;
  localparam int STAT_W = 9;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

//--- hw/tpw_match_reg.sv
`timescale 1ns/10ps
module tpw_match_reg #(
  parameter int W = 32
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic apply_i,
  input wire logic step_i,
  input wire logic [W-1:0] cnt_i,
  output logic [W-1:0] shadow_o,
  output logic hit_o
);
  logic [W-1:0] active;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shadow_o <= W'(tpw_pkg::RST_WORD);
    end else if (wr_i) begin
      shadow_o <= wdata_i;
    end
  end

  // Active value only moves when released, so a half-updated pair never
  // shapes a pulse
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      active <= W'(tpw_pkg::RST_WORD);
    end else if (apply_i) begin
      active <= shadow_o;
    end
  end

  assign hit_o = step_i & (cnt_i == active);
endmodule

//--- hw/tpw_timer_pwm.sv
// Notes on behaviour
// - 32-bit counter steps once per terminal count of a 32-bit prescaler.
// - Counts internal clock cycles, or transitions on a selected capture input.
// - Two capture channels latch the counter on input edges, optional interrupt.
// - Seven match values each may interrupt, stop or reset the counter.
// - Four match pins go low, high, toggle or hold on their match.
// - Matches 0 and 1 can each issue a DMA request pulse.
// - PWM variant has seven match values; outputs follow only match events.
// - In PWM mode the cycle-period match resets the counter for all outputs.
// - Single-edge output uses one own match value for its falling edge.
// - Single-edge outputs rise when the cycle-period match occurs.
// - Double-edge output uses two match values, for rise and for fall.
// - Rise before fall gives a positive pulse, fall first a negative one.
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module tpw_timer_pwm #(
  parameter int CNT_W = 32
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [tpw_pkg::NUM_CAP-1:0] cap_i,
  output logic [tpw_pkg::NUM_EXT-1:0] ext_match_o,
  output logic [tpw_pkg::NUM_PWM-1:0] pwm_o,
  output logic [tpw_pkg::NUM_PWM-1:0] pwm_oe_o,
  output logic [tpw_pkg::NUM_DMA-1:0] dma_req_o,
  output logic irq_o
);
  localparam int NM = tpw_pkg::NUM_MATCH;
  localparam int NC = tpw_pkg::NUM_CAP;
  localparam int NE = tpw_pkg::NUM_EXT;
  localparam int NP = tpw_pkg::NUM_PWM;
  localparam int SW = tpw_pkg::STAT_W;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Bus slave: one wait cycle, then the access completes
  logic ack;
  logic wr_go;
  logic [5:0] widx;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign wr_go = avs_write_i & ack;
  assign widx = avs_address_i[7:2];

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (avs_read_i | avs_write_i) & ~ack;
    end
  end

  function automatic logic wsel(input logic [7:0] ofs, input logic go, input logic [5:0] idx);
    return go && (idx == ofs[7:2]);
  endfunction

  logic [31:0] ctrl;
  logic [CNT_W-1:0] tc;
  logic [31:0] pr;
  logic [31:0] pc;
  logic [31:0] mcr;
  logic [31:0] ccr;
  logic [CNT_W-1:0] cap_val [NC];
  logic [31:0] cnt_cfg;
  logic [31:0] emr;
  logic [31:0] pcr;
  logic [NM-1:0] ler;
  logic [SW-1:0] stat;
  logic [SW-1:0] mask;
  logic [NC-1:0] cap_q;

  logic pwm_mode;
  logic run;
  logic tick;
  logic step;
  logic [NM-1:0] hit;
  logic [NM-1:0] mint_v;
  logic [NM-1:0] mrst_v;
  logic [NM-1:0] mstop_v;
  logic match_rst;
  logic match_stop;
  logic [NC-1:0] cap_rise;
  logic [NC-1:0] cap_fall;
  logic [NC-1:0] cap_ev;
  logic [NC-1:0] cap_int;
  logic [CNT_W-1:0] mr_shadow [NM];

  assign pwm_mode = ctrl[tpw_pkg::CTRL_PWM];
  assign run = ctrl[tpw_pkg::CTRL_EN] & ~ctrl[tpw_pkg::CTRL_RST];
  assign cap_rise = cap_i & ~cap_q;
  assign cap_fall = ~cap_i & cap_q;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cap_q <= '0;
    end else begin
      cap_q <= cap_i;
    end
  end

  // Count source: every clock, or edges of the selected capture input
  always_comb begin
    logic r;
    logic f;
    r = cap_rise[cnt_cfg[tpw_pkg::CNT_SEL]];
    f = cap_fall[cnt_cfg[tpw_pkg::CNT_SEL]];
    case (cnt_cfg[1:0])
      tpw_pkg::CNT_TIMER: tick = 1'b1;
      tpw_pkg::CNT_RISE: tick = r;
      tpw_pkg::CNT_FALL: tick = f;
      tpw_pkg::CNT_BOTH: tick = r | f;
      default: tick = 1'b0;
    endcase
  end

  assign step = run & tick & (pc == pr);

  always_comb begin
    for (int n = 0; n < NM; n++) begin
      mint_v[n] = mcr[n*tpw_pkg::MCR_W + tpw_pkg::MCR_INT];
      mrst_v[n] = mcr[n*tpw_pkg::MCR_W + tpw_pkg::MCR_RST];
      mstop_v[n] = mcr[n*tpw_pkg::MCR_W + tpw_pkg::MCR_STOP];
    end
  end

  assign match_rst = |(hit & mrst_v) | (pwm_mode & hit[0]);
  assign match_stop = |(hit & mstop_v);

  // Match channels
  for (genvar n = 0; n < NM; n++) begin : g_match
    logic apply;
    logic wr;
    // In PWM mode a new value waits for release and the start of a cycle
    assign apply = ~pwm_mode | (hit[0] & ler[n]);
    assign wr = wsel(tpw_pkg::OFS_MR0 + 8'(4*n), wr_go, widx);
    tpw_match_reg #(.W(CNT_W)) u_mr (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .wr_i(wr),
      .wdata_i(CNT_W'(be_merge(32'(mr_shadow[n]), avs_writedata_i, avs_byteenable_i))),
      .apply_i(apply),
      .step_i(step),
      .cnt_i(tc),
      .shadow_o(mr_shadow[n]),
      .hit_o(hit[n])
    );
  end

  // Control: a stop match wins over a software enable in the same cycle
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl <= tpw_pkg::RST_WORD;
    end else begin
      if (wsel(tpw_pkg::OFS_CTRL, wr_go, widx)) begin
        ctrl <= be_merge(ctrl, avs_writedata_i, avs_byteenable_i);
      end
      if (match_stop) begin
        ctrl[tpw_pkg::CTRL_EN] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tc <= CNT_W'(tpw_pkg::RST_WORD);
    end else if (ctrl[tpw_pkg::CTRL_RST]) begin
      tc <= CNT_W'(tpw_pkg::RST_WORD);
    end else if (wsel(tpw_pkg::OFS_TC, wr_go, widx)) begin
      tc <= CNT_W'(be_merge(32'(tc), avs_writedata_i, avs_byteenable_i));
    end else if (step) begin
      tc <= match_rst ? CNT_W'(tpw_pkg::RST_WORD) : tc + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pc <= tpw_pkg::RST_WORD;
    end else if (ctrl[tpw_pkg::CTRL_RST] || step) begin
      pc <= tpw_pkg::RST_WORD;
    end else if (run && tick) begin
      pc <= pc + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pr <= tpw_pkg::RST_WORD;
      mcr <= tpw_pkg::RST_WORD;
      ccr <= tpw_pkg::RST_WORD;
      cnt_cfg <= tpw_pkg::RST_WORD;
      pcr <= tpw_pkg::RST_WORD;
      mask <= '0;
    end else begin
      if (wsel(tpw_pkg::OFS_PR, wr_go, widx)) begin
        pr <= be_merge(pr, avs_writedata_i, avs_byteenable_i);
      end
      if (wsel(tpw_pkg::OFS_MCR, wr_go, widx)) begin
        mcr <= be_merge(mcr, avs_writedata_i, avs_byteenable_i);
      end
      if (wsel(tpw_pkg::OFS_CCR, wr_go, widx)) begin
        ccr <= be_merge(ccr, avs_writedata_i, avs_byteenable_i);
      end
      if (wsel(tpw_pkg::OFS_CNT, wr_go, widx)) begin
        cnt_cfg <= be_merge(cnt_cfg, avs_writedata_i, avs_byteenable_i);
      end
      if (wsel(tpw_pkg::OFS_PCR, wr_go, widx)) begin
        pcr <= be_merge(pcr, avs_writedata_i, avs_byteenable_i);
      end
      if (wsel(tpw_pkg::OFS_MASK, wr_go, widx)) begin
        mask <= SW'(be_merge(32'(mask), avs_writedata_i, avs_byteenable_i));
      end
    end
  end

  // Release bits: a software write wins over the hardware clear
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ler <= '0;
    end else if (wsel(tpw_pkg::OFS_LER, wr_go, widx)) begin
      ler <= NM'(be_merge(32'(ler), avs_writedata_i, avs_byteenable_i));
    end else if (pwm_mode && hit[0]) begin
      ler <= '0;
    end
  end

  // Captures
  always_comb begin
    for (int i = 0; i < NC; i++) begin
      cap_ev[i] = (cap_rise[i] & ccr[i*tpw_pkg::CCR_W + tpw_pkg::CCR_RISE]) |
                  (cap_fall[i] & ccr[i*tpw_pkg::CCR_W + tpw_pkg::CCR_FALL]);
      cap_int[i] = cap_ev[i] & ccr[i*tpw_pkg::CCR_W + tpw_pkg::CCR_INT];
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NC; i++) begin
        cap_val[i] <= CNT_W'(tpw_pkg::RST_WORD);
      end
    end else begin
      for (int i = 0; i < NC; i++) begin
        if (cap_ev[i]) begin
          cap_val[i] <= tc;
        end
      end
    end
  end

  // External match pins follow their match action
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      emr <= tpw_pkg::RST_WORD;
    end else begin
      if (wsel(tpw_pkg::OFS_EMR, wr_go, widx)) begin
        emr <= be_merge(emr, avs_writedata_i, avs_byteenable_i);
      end
      for (int n = 0; n < NE; n++) begin
        if (hit[n]) begin
          case (emr[tpw_pkg::EMR_CTL_LSB + 2*n +: 2])
            tpw_pkg::EXT_LOW: emr[n] <= 1'b0;
            tpw_pkg::EXT_HIGH: emr[n] <= 1'b1;
            tpw_pkg::EXT_TOG: emr[n] <= ~emr[n];
            default: emr[n] <= emr[n];
          endcase
        end
      end
    end
  end

  assign ext_match_o = emr[NE-1:0];

  // Clear wins, so a fall match equal to the period match holds an output low
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwm_o <= '0;
    end else if (pwm_mode) begin
      for (int k = 0; k < NP; k++) begin
        logic set_e;
        set_e = ((k >= 1) && pcr[k+1]) ? hit[k] : hit[0];
        if (hit[k+1]) begin
          pwm_o[k] <= 1'b0;
        end else if (set_e) begin
          pwm_o[k] <= 1'b1;
        end
      end
    end
  end

  assign pwm_oe_o = pcr[tpw_pkg::PCR_OE_LSB +: NP];

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dma_req_o <= '0;
    end else begin
      dma_req_o <= hit[1:0] & ctrl[tpw_pkg::CTRL_DMA0 +: 2];
    end
  end

  // Interrupt status: write one to clear, a new event wins over the clear
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    logic [SW-1:0] clr;
    logic [SW-1:0] set_v;
    if (!nrst_i) begin
      stat <= '0;
    end else begin
      clr = '0;
      if (wsel(tpw_pkg::OFS_STAT, wr_go, widx)) begin
        clr = SW'(be_merge(tpw_pkg::RST_WORD, avs_writedata_i, avs_byteenable_i));
      end
      set_v = '0;
      set_v[NM-1:0] = hit & mint_v;
      set_v[tpw_pkg::STAT_CAP_LSB +: NC] = cap_int;
      stat <= (stat & ~clr) | set_v;
    end
  end

  assign irq_o = |(stat & mask);

  // Read data is loaded as the wait cycle ends
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= tpw_pkg::RST_WORD;
    end else if (avs_read_i && !ack) begin
      case (avs_address_i & 8'hFC)
        tpw_pkg::OFS_STAT: avs_readdata_o <= 32'(stat);
        tpw_pkg::OFS_CTRL: avs_readdata_o <= ctrl;
        tpw_pkg::OFS_TC: avs_readdata_o <= 32'(tc);
        tpw_pkg::OFS_PR: avs_readdata_o <= pr;
        tpw_pkg::OFS_PC: avs_readdata_o <= pc;
        tpw_pkg::OFS_MCR: avs_readdata_o <= mcr;
        tpw_pkg::OFS_CCR: avs_readdata_o <= ccr;
        tpw_pkg::OFS_CAP0: avs_readdata_o <= 32'(cap_val[0]);
        tpw_pkg::OFS_CAP1: avs_readdata_o <= 32'(cap_val[1]);
        tpw_pkg::OFS_CNT: avs_readdata_o <= cnt_cfg;
        tpw_pkg::OFS_EMR: avs_readdata_o <= emr;
        tpw_pkg::OFS_PCR: avs_readdata_o <= pcr;
        tpw_pkg::OFS_LER: avs_readdata_o <= 32'(ler);
        tpw_pkg::OFS_MASK: avs_readdata_o <= 32'(mask);
        default: begin
          if (widx >= tpw_pkg::OFS_MR0[7:2] && 32'(widx - tpw_pkg::OFS_MR0[7:2]) < NM) begin
            avs_readdata_o <= 32'(mr_shadow[3'(widx - tpw_pkg::OFS_MR0[7:2])]);
          end else begin
            avs_readdata_o <= tpw_pkg::RST_WORD;
          end
        end
      endcase
    end
  end
endmodule

//--- test/tpw_timer_pwm_assertions.sv
`timescale 1ns/10ps
module tpw_checker (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [tpw_pkg::NUM_PWM-1:0] pwm_o,
  input wire logic [tpw_pkg::NUM_PWM-1:0] pwm_oe_o,
  input wire logic [tpw_pkg::NUM_DMA-1:0] dma_req_o,
  input wire logic irq_o
);
  logic pwm_md;
  logic [1:0] dma_en;
  logic [5:0] oe_sh;
  logic [8:0] mask_sh;
  logic wr_ok;
  assign wr_ok = avs_write_i && !avs_waitrequest_o;
  // Mirrors whole-word writes only; partial lane writes would leave them stale
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pwm_md <= 1'b0;
      dma_en <= 2'h0;
      oe_sh <= 6'h00;
      mask_sh <= 9'h000;
    end else if (wr_ok && avs_byteenable_i == 4'hF) begin
      if (avs_address_i == tpw_pkg::OFS_CTRL) begin
        pwm_md <= avs_writedata_i[tpw_pkg::CTRL_PWM];
        dma_en <= avs_writedata_i[tpw_pkg::CTRL_DMA0 +: 2];
      end
      if (avs_address_i == tpw_pkg::OFS_PCR) oe_sh <= avs_writedata_i[14:9];
      if (avs_address_i == tpw_pkg::OFS_MASK) mask_sh <= avs_writedata_i[8:0];
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  a_wait_first: assert property ($rose(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("request answered without a wait cycle");
  a_wait_once: assert property (avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("wait lasted more than one cycle");
  a_idle_nowait: assert property (!avs_read_i && !avs_write_i |-> !avs_waitrequest_o)
    else $error("wait raised with no request");
  a_rdata_stands: assert property (!$past(avs_read_i && avs_waitrequest_o) |-> $stable(avs_readdata_o))
    else $error("read data moved outside a read");
  a_oe_follows: assert property (pwm_oe_o == oe_sh)
    else $error("output enables differ from written value");
  a_pwm_hold: assert property (!pwm_md |=> $stable(pwm_o))
    else $error("pwm output moved outside pwm mode");
  a_dma_gated: assert property (|dma_req_o |-> (dma_req_o & ~($past(dma_en) | $past(dma_en, 2))) == 2'h0)
    else $error("dma request while disabled");
  a_irq_masked: assert property (irq_o |-> mask_sh != 9'h000)
    else $error("interrupt with every source masked");

  c_irq_up: cover property ($rose(irq_o));
  c_dma_pulse: cover property (dma_req_o[0]);
  c_pwm_fall: cover property ($fell(pwm_o[0]));
endmodule

bind tpw_timer_pwm tpw_checker u_chk (
  .core_clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .pwm_o, .pwm_oe_o, .dma_req_o,
  .irq_o
);

//--- test/tpw_pins_model.sv
`timescale 1ns/10ps
module tpw_pins (
  input wire logic core_clk_i,
  input wire logic [5:0] pwm_i,
  input wire logic [3:0] ext_i,
  input wire logic [1:0] dma_i,
  output logic [1:0] cap_o
);
  int cyc = 0;
  int t_rise[8];
  int per[8];
  int wid[8];
  logic [7:0] v;
  logic [7:0] v_q = 8'h00;
  assign v = {dma_i[0], ext_i[0], pwm_i};
  initial cap_o = 2'h0;
  // Period from rise to rise, width from rise to fall, in clock cycles
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    v_q <= v;
    for (int i = 0; i < 8; i++) begin
      if (v[i] && !v_q[i]) begin
        per[i] <= cyc - t_rise[i];
        t_rise[i] <= cyc;
      end
      if (!v[i] && v_q[i]) wid[i] <= cyc - t_rise[i];
    end
  end
  // Each level held two cycles so every edge is seen
  task automatic strobe(input int ch, input int n);
    repeat (n) begin
      cap_o[ch] <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      cap_o[ch] <= 1'b0;
      repeat (2) @(posedge core_clk_i);
    end
  endtask
endmodule

//--- test/tpw_timer_pwm_bench.sv
`timescale 1ns/10ps
module tpw_timer_pwm_bench;
  logic core_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] cap_i;
  logic [3:0] ext_match_o;
  logic [5:0] pwm_o;
  logic [5:0] pwm_oe_o;
  logic [1:0] dma_req_o;
  logic irq_o;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0;
  logic [31:0] rv;
  int mrv[6] = '{9, 3, 2, 7, 8, 1};
  int exw[5] = '{4, 3, 5, 9, 3};

  tpw_timer_pwm dut (.core_clk_i, .nrst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .cap_i,
    .ext_match_o, .pwm_o, .pwm_oe_o, .dma_req_o, .irq_o);
  tpw_pins pins (.core_clk_i, .pwm_i(pwm_o), .ext_i(ext_match_o), .dma_i(dma_req_o),
    .cap_o(cap_i));

  always #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end

  task automatic conclude();
    if (n_fail == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cn(input int got, input int exp);
    chk(32'(got), 32'(exp));
  endtask
  // Request held until the edge that sees the wait dropped
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    @(posedge core_clk_i);
    while (avs_waitrequest_o) @(posedge core_clk_i);
    rv = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rv, e);
  endtask
  function automatic logic [7:0] mra(input int i);
    return tpw_pkg::OFS_MR0 + 8'(4 * i);
  endfunction

  initial begin
    repeat (3) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    rd(tpw_pkg::OFS_CTRL, tpw_pkg::RST_WORD);
    rd(tpw_pkg::OFS_STAT, tpw_pkg::RST_WORD);
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0);
    for (int i = 0; i < tpw_pkg::NUM_MATCH; i++) wr(mra(i), 32'h100 + 32'(i));
    for (int i = 0; i < tpw_pkg::NUM_MATCH; i++) rd(mra(i), 32'h100 + 32'(i));
    wr(tpw_pkg::OFS_PR, 32'h3);
    wr(tpw_pkg::OFS_CTRL, 32'h2);
    wr(tpw_pkg::OFS_CTRL, 32'h1);
    t0 = cyc;
    repeat (37) @(posedge core_clk_i);
    wr(tpw_pkg::OFS_CTRL, 32'h0);
    t0 = cyc - t0;
    rd(tpw_pkg::OFS_TC, 32'(t0 / 4));
    rd(tpw_pkg::OFS_PC, 32'(t0 % 4));
    wr(tpw_pkg::OFS_CCR, 32'h28);
    wr(tpw_pkg::OFS_MASK, 32'h100);
    pins.strobe(1, 1);
    rd(tpw_pkg::OFS_CAP1, 32'(t0 / 4));
    rd(tpw_pkg::OFS_CAP0, 32'h0);
    chk({31'h0, irq_o}, 32'h1);
    rd(tpw_pkg::OFS_STAT, 32'h100);
    wr(tpw_pkg::OFS_MASK, 32'h0);
    chk({31'h0, irq_o}, 32'h0);
    wr(tpw_pkg::OFS_STAT, 32'h100);
    rd(tpw_pkg::OFS_STAT, 32'h0);
    wr(tpw_pkg::OFS_PR, 32'h0);
    wr(tpw_pkg::OFS_CCR, 32'h2);
    for (int m = 1; m < 4; m++) begin
      wr(tpw_pkg::OFS_CNT, 32'(m));
      wr(tpw_pkg::OFS_CTRL, 32'h2);
      wr(tpw_pkg::OFS_CTRL, 32'h1);
      pins.strobe(0, 5);
      rd(tpw_pkg::OFS_TC, (m == 3) ? 32'hA : 32'h5);
    end
    rd(tpw_pkg::OFS_CAP0, 32'h9);
    wr(tpw_pkg::OFS_CNT, 32'h0);
    // Match 1 shares match 0's value to exercise simultaneous hits
    wr(mra(0), 32'h4);
    wr(mra(1), 32'h4);
    wr(mra(2), 32'h0);
    wr(mra(3), 32'h0);
    wr(tpw_pkg::OFS_MCR, 32'hB);
    wr(tpw_pkg::OFS_MASK, 32'h2);
    wr(tpw_pkg::OFS_EMR, 32'h1BC);
    wr(tpw_pkg::OFS_CTRL, 32'h2);
    wr(tpw_pkg::OFS_CTRL, 32'h9);
    repeat (60) @(posedge core_clk_i);
    chk({29'h0, ext_match_o[3:1]}, 32'h5);
    cn(pins.per[6], 10);
    cn(pins.per[7], 5);
    cn(pins.wid[7], 1);
    rd(tpw_pkg::OFS_STAT, 32'h3);
    chk({31'h0, irq_o}, 32'h1);
    wr(tpw_pkg::OFS_MCR, 32'h23);
    repeat (20) @(posedge core_clk_i);
    rd(tpw_pkg::OFS_CTRL, 32'h8);
    rd(tpw_pkg::OFS_TC, 32'h0);
    wr(tpw_pkg::OFS_STAT, 32'h3);
    chk({31'h0, irq_o}, 32'h0);
    wr(tpw_pkg::OFS_MCR, 32'h0);
    wr(tpw_pkg::OFS_EMR, 32'h0);
    for (int i = 0; i < 6; i++) wr(mra(i), 32'(mrv[i]));
    wr(tpw_pkg::OFS_PCR, 32'h7E28);
    wr(tpw_pkg::OFS_CTRL, 32'h2);
    wr(tpw_pkg::OFS_CTRL, 32'h5);
    repeat (60) @(posedge core_clk_i);
    chk({26'h0, pwm_oe_o}, 32'h3F);
    cn(pins.per[0], 10);
    cn(pins.per[2], 10);
    cn(pins.t_rise[0], pins.t_rise[1]);
    for (int i = 0; i < 5; i++) cn(pins.wid[i], exw[i]);
    // A new edge position waits in the shadow until released
    wr(mra(1), 32'h5);
    rd(mra(1), 32'h5);
    repeat (20) @(posedge core_clk_i);
    cn(pins.wid[0], 4);
    wr(tpw_pkg::OFS_LER, 32'h2);
    repeat (30) @(posedge core_clk_i);
    rd(tpw_pkg::OFS_LER, 32'h0);
    cn(pins.wid[0], 6);
    conclude();
  end
endmodule
